/* src/gitd_debounce.sv */
/*
 * Pulse-width debounce filter for one trigger input.
 * Assumes the input is already synchronised and a one-microsecond tick.
 */
`timescale 1ns/1ps
module gitd_debounce
   import gitd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              tick,
   input  wire logic              level_in,
   input  wire logic [DEB_W-1:0]  debounce_us,
   output logic                   valid_pulse
);

   logic [DEB_W-1:0] count_reg;
   logic             fired_reg;
   logic [DEB_W-1:0] limit;

   assign limit = (debounce_us == DEB_ZERO) ? DEB_MIN_US : debounce_us;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= DEB_ZERO;
      end else if (!level_in) begin
         count_reg <= DEB_ZERO;
      end else if (tick && count_reg != limit) begin
         count_reg <= count_reg + DEB_MIN_US;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fired_reg   <= 1'b0;
         valid_pulse <= 1'b0;
      end else begin
         valid_pulse <= level_in && !fired_reg && count_reg == limit;
         if (!level_in) begin
            fired_reg <= 1'b0;
         end else if (count_reg == limit) begin
            fired_reg <= 1'b1;
         end
      end
   end

endmodule

/* src/gitd_pkg.sv */
/*
 * Package for the general input, trigger and debounce block.
 * Assumes a single 10 MHz board clock.
 */
package gitd_pkg;

   localparam int          CLK_HZ        = 10000000;
   localparam int          TICK_US       = 1;
   localparam int          TICK_CYCLES   = (CLK_HZ / 1000000) * TICK_US;
   localparam int          TICK_W        = 4;
   localparam logic [3:0]  TICK_LAST     = 4'(TICK_CYCLES - 1);
   localparam int          DEB_W         = 8;
   localparam logic [7:0]  DEB_MIN_US    = 8'h01;
   localparam logic [7:0]  DEB_ZERO      = 8'h00;
   localparam int          NUM_GIN       = 4;
   localparam int          NUM_TRIG      = 2;
   localparam int          NUM_GOUT      = 8;
   localparam int          NUM_STROBE    = 2;

   typedef enum logic [1:0] {
      GITD_SRC_NONE,
      GITD_SRC_IN1,
      GITD_SRC_IN2
   } gitd_src_t;

   typedef struct packed {
      gitd_src_t        trig_src;
      logic             trig_active_low;
      logic             two_pulse_en;
      logic [1:0]       strobe_sel;
      logic [7:0]       debounce_us;
   } gitd_cfg_t;

endpackage

/* src/gitd_top.sv */
/*
 * General input conditioning, external trigger and strobe output muxing.
 * Assumes pins are asynchronous and configuration is quasi-static.
 */
//
// Behaviour
// - Debounce time is programmable per trigger input from 1 to 255 us.
// - A trigger pulse shorter than the debounce time produces no event.
// - A debounce setting of zero acts as one microsecond.
// - General input one can be picked as trigger source, and input two when two-pulse mode is off.
// - Each general input raises its own interrupt and is readable.
// - In two-pulse mode input two ends the frame input one started.
// - Outputs one and two come from software or from the strobe logic.
// - A trigger is valid only when held beyond isolator delay plus debounce.
// - A software trigger gives the same event as a validated trigger.
`timescale 1ns/1ps
module gitd_top
   import gitd_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [NUM_GIN-1:0]    gin_pin,
   input  wire gitd_cfg_t             cfg,
   input  wire logic [DEB_W-1:0]      debounce2_us,
   input  wire logic                  sw_trigger,
   input  wire logic [NUM_GOUT-1:0]   sw_gout,
   input  wire logic [NUM_GOUT-1:0]   gout_en,
   input  wire logic [NUM_STROBE-1:0] strobe_in,
   output logic [NUM_GIN-1:0]         gin_state,
   output logic [NUM_GIN-1:0]         gin_irq,
   output logic                       acq_trigger,
   output logic                       frame_end,
   output logic                       frame_active,
   output logic [NUM_GOUT-1:0]        gout_pin,
   output logic [NUM_GOUT-1:0]        gout_oe_b
);

   ////////////////////////////////////////////////////////////////////////
   logic [NUM_GIN-1:0]  sync1_reg;
   logic [NUM_GIN-1:0]  sync2_reg;
   logic [NUM_TRIG-1:0] trig_level;
   logic [NUM_TRIG-1:0] tick;
   logic [NUM_GOUT-1:0] gout_src;
   logic [NUM_TRIG-1:0] valid;
   logic [DEB_W-1:0]    deb_set [NUM_TRIG];
   logic                trig_next;

   // Two-stage synchroniser; only sync2 is read by logic.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= gin_pin;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gin_state <= '0;
         gin_irq   <= '0;
      end else begin
         gin_state <= sync2_reg;
         gin_irq   <= sync2_reg ^ gin_state;
      end
   end

   assign deb_set[0]  = cfg.debounce_us;
   assign deb_set[1]  = debounce2_us;
   assign trig_level  = cfg.trig_active_low ? ~sync2_reg[NUM_TRIG-1:0]
                                            : sync2_reg[NUM_TRIG-1:0];

   generate
      for (genvar i = 0; i < NUM_TRIG; i++) begin : g_deb
         logic [TICK_W-1:0] tick_cnt_reg;

         // microsecond tick
         // The prescaler restarts with every rising level, so a pulse is
         // timed from its own start and never inherits part of a tick.
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               tick_cnt_reg <= '0;
            end else if (!trig_level[i] || tick_cnt_reg == TICK_LAST) begin
               tick_cnt_reg <= '0;
            end else begin
               tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
         end
         assign tick[i] = trig_level[i] && (tick_cnt_reg == TICK_LAST);

         gitd_debounce u_deb (
            .clk         (clk),
            .rst_b       (rst_b),
            .tick        (tick[i]),
            .level_in    (trig_level[i]),
            .debounce_us (deb_set[i]),
            .valid_pulse (valid[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // trigger source select
   always_comb begin
      case (cfg.trig_src)
         GITD_SRC_IN1: trig_next = valid[0];
         GITD_SRC_IN2: trig_next = valid[1] && !cfg.two_pulse_en;
         GITD_SRC_NONE: trig_next = 1'b0;
         default: trig_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acq_trigger <= 1'b0;
      end else begin
         acq_trigger <= trig_next || sw_trigger;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_active <= 1'b0;
         frame_end    <= 1'b0;
      end else begin
         frame_end <= cfg.two_pulse_en && frame_active && valid[1];
         if (!cfg.two_pulse_en) begin
            frame_active <= 1'b0;
         end else if (trig_next || sw_trigger) begin
            frame_active <= 1'b1;
         end else if (valid[1]) begin
            frame_active <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strobe or software drive
   // Only the first outputs have a strobe source; the rest follow software.
   generate
      for (genvar k = 0; k < NUM_GOUT; k++) begin : g_gout
         if (k < NUM_STROBE) begin : g_strb
            assign gout_src[k] = cfg.strobe_sel[k] ? strobe_in[k] : sw_gout[k];
         end else begin : g_soft
            assign gout_src[k] = sw_gout[k];
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gout_pin  <= '0;
         gout_oe_b <= '1;
      end else begin
         gout_pin  <= gout_src;
         gout_oe_b <= ~gout_en;
      end
   end

endmodule

/* test/gitd_bench.sv */
/* Self-checking bench for gitd_top.
   Assumes the field model drives the input pins. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   error_cnt++; $display("mismatch %0t bad value", $time); end end
module gitd_bench
   import gitd_pkg::*;
;
   logic       clk, rst_b, sw_trigger, acq_trigger, frame_end, frame_active;
   logic [3:0] lvl, gin_pin, gin_state, gin_irq;
   logic [7:0] debounce2_us, sw_gout, gout_en, gout_pin, gout_oe_b;
   logic [1:0] strobe_in;
   gitd_cfg_t  cfg;
   int         error_cnt, total_checks, n_trig, n_end;
   localparam logic [27:0] ROWS [4] = '{28'h3a5ffa5, 28'hea50fa6,
      28'h53cf03d, 28'ha000002};
   gitd_top u_dut (.*);
   gitd_field u_fld (.lvl(lvl), .gin_pin(gin_pin));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      n_trig += (acq_trigger !== 1'b0);
      n_end += (frame_end !== 1'b0);
   end
   task automatic report_and_stop();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic pulse(input int ch, input int w, input int exp);
      n_trig = 0;
      lvl[ch] = 1'b1;
      repeat (w) @(negedge clk);
      lvl[ch] = 1'b0;
      repeat (30) @(negedge clk);
      `CHK(n_trig, exp)
   endtask
   initial begin
      #2000000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      {rst_b, sw_trigger, lvl, cfg, debounce2_us, sw_gout, gout_en,
         strobe_in} = '0;
      repeat (2) @(negedge clk);
      `CHK(gout_oe_b, 8'hff)
      rst_b = 1'b1;
      foreach (ROWS[i]) begin
         {cfg.strobe_sel, strobe_in, sw_gout, gout_en} = ROWS[i][27:8];
         @(negedge clk);
         `CHK(gout_pin, ROWS[i][7:0])
         `CHK(gout_oe_b, ~ROWS[i][15:8])
      end
      lvl = 4'hc;
      repeat (3) @(negedge clk);
      `CHK(gin_irq, 4'hc)
      @(negedge clk);
      `CHK(gin_irq, 4'h0)
      repeat (2) @(negedge clk);
      `CHK(gin_state, 4'hc)
      lvl = 4'h0;
      @(negedge clk);
      cfg.debounce_us = 8'h03;
      debounce2_us = 8'h03;
      for (int ch = 0; ch < 2; ch++) begin
         cfg.trig_src = gitd_src_t'(ch + 1);
         pulse(ch, 29, 0);
         pulse(ch, 40, 1);
      end
      debounce2_us = 8'h05;
      pulse(1, 40, 0);
      pulse(1, 60, 1);
      cfg.debounce_us = 8'hff;
      cfg.trig_src = GITD_SRC_IN1;
      pulse(0, 2540, 0);
      pulse(0, 2560, 1);
      cfg.debounce_us = 8'h00;
      pulse(0, 8, 0);
      pulse(0, 12, 1);
      lvl[0] = 1'b1;
      cfg.trig_active_low = 1'b1;
      repeat (5) @(negedge clk);
      n_trig = 0;
      lvl[0] = 1'b0;
      repeat (15) @(negedge clk);
      lvl[0] = 1'b1;
      repeat (5) @(negedge clk);
      `CHK(n_trig, 1)
      cfg.trig_active_low = 1'b0;
      lvl[0] = 1'b0;
      n_trig = 0;
      sw_trigger = 1'b1;
      repeat (2) @(negedge clk);
      sw_trigger = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(n_trig, 2)
      cfg.two_pulse_en = 1'b1;
      n_end = 0;
      sw_trigger = 1'b1;
      @(negedge clk);
      sw_trigger = 1'b0;
      @(negedge clk);
      `CHK(frame_active, 1'b1)
      pulse(1, 60, 0);
      `CHK(n_end, 1)
      `CHK(frame_active, 1'b0)
      pulse(0, 12, 1);
      `CHK(frame_active, 1'b1)
      cfg.trig_src = GITD_SRC_IN2;
      pulse(1, 60, 0);
      `CHK(n_end, 2)
      `CHK(frame_active, 1'b0)
      sw_trigger = 1'b1;
      @(negedge clk);
      sw_trigger = 1'b0;
      rst_b = 1'b0;
      @(negedge clk);
      `CHK(frame_active, 1'b0)
      `CHK(gout_pin, 8'h00)
      @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(gout_pin, 8'h02)
      `CHK(frame_active, 1'b0)
      report_and_stop();
   end
endmodule

/* test/gitd_checker.sv */
/* Port assertions for gitd_top.
   Assumes a bind onto gitd_top with matching port names. */
`timescale 1ns/1ps
module gitd_checker
   import gitd_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [3:0] gin_pin,
   input wire gitd_cfg_t  cfg,
   input wire logic       sw_trigger,
   input wire logic [7:0] gout_en,
   input wire logic [3:0] gin_state,
   input wire logic [3:0] gin_irq,
   input wire logic       acq_trigger,
   input wire logic       frame_end,
   input wire logic       frame_active,
   input wire logic [7:0] gout_oe_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_sw; sw_trigger |=> acq_trigger; endproperty
   a_sw: assert property (p_sw) else $error("sw trigger lost");
   property p_fa; cfg.two_pulse_en && sw_trigger |=> frame_active; endproperty
   a_fa: assert property (p_fa) else $error("no frame start");
   property p_fe; frame_end |-> $past(frame_active); endproperty
   a_fe: assert property (p_fe) else $error("end without frame");
   property p_fx; frame_end && !acq_trigger |-> !frame_active; endproperty
   a_fx: assert property (p_fx) else $error("frame still open");
   property p_nf; !$past(cfg.two_pulse_en) |-> !frame_end; endproperty
   a_nf: assert property (p_nf) else $error("stray frame end");
   property p_irq; $changed(gin_pin[0]) |-> ##[1:5] gin_irq[0]; endproperty
   a_irq: assert property (p_irq) else $error("no input irq");
   property p_st;
      $stable(gin_pin)[*4] |=> gin_state == $past(gin_pin);
   endproperty
   a_st: assert property (p_st) else $error("state stale");
   property p_oe; $past(rst_b) |-> gout_oe_b == ~$past(gout_en); endproperty
   a_oe: assert property (p_oe) else $error("enable wrong");
   c_trig: cover property (acq_trigger);
   c_end: cover property (frame_end);
   c_irq: cover property (gin_irq[1]);
endmodule
bind gitd_top gitd_checker u_chk (.*);

/* test/gitd_field.sv */
/* Field model of trigger sources and sensors on the inputs.
   Assumes the bench sets levels off the rising clock edge. */
`timescale 1ns/1ps
module gitd_field (
   input wire logic [3:0] lvl,
   output logic [3:0]     gin_pin
);
   assign gin_pin = lvl;
endmodule
